// *** rtl/pid_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the PID controller
`ifndef PID_REGS_SVH
`define PID_REGS_SVH

// Serial-bus registers at their printed offsets
`define ADR_SER_SP     16'h0006
`define ADR_SER_SEL    16'h000F
`define SER_SEL_SP_BIT 1

// Setting registers, then the read-only status and PID output
`define ADR_MODE       16'h0100
`define ADR_GAIN       16'h0101
`define ADR_TI         16'h0102
`define ADR_TD         16'h0103
`define ADR_AIN1_FUNC  16'h0104
`define ADR_AIN2_FUNC  16'h0105
`define ADR_PULSE_FUNC 16'h0106
`define ADR_SP_SEL     16'h0107
`define ADR_SP_VAL     16'h0108
`define ADR_STATUS     16'h0110
`define ADR_PID_OUT    16'h0111

// Status bit positions
`define ST_SP_ERR  0
`define ST_FB_ERR  1
`define ST_FB2_ERR 2
`define ST_DIFF    3
`define ST_ACTIVE  4

// Limits and reset values
`define MODE_MAX   3'h4
`define MODE_RST   3'h0
`define GAIN_MAX   16'h09C4
`define GAIN_RST   16'h0064
`define TI_RST     16'h000A
`define TD_RST     16'h0000

// Function codes
`define FN_SP       8'h0C
`define FN_FB       8'h0B
`define FN_FB2      8'h16
`define PULSE_FN_FB 8'h01
`define PULSE_FN_SP 8'h02

// Timing: control period and scale of time settings, then the gain scale
`define CLK_MHZ        25
`define CTRL_PERIOD_US 1000
`define TI_TICKS       48'sh64
`define TD_TICKS       48'shA
`define GAIN_SCALE     48'sh64

`endif

// *** rtl/pid_pkg.sv ***
// Types shared by the PID frequency controller
`default_nettype none

package pid_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CALC  = 2'b01,
    ST_APPLY = 2'b11
  } phase_t;

  typedef struct packed {
    logic signed [15:0] a_one;
    logic signed [15:0] a_two;
    logic signed [15:0] pulse;
    logic signed [15:0] fref;
  } sense_t;

  typedef struct packed {
    logic [2:0]  pid_mode_setting;
    logic [15:0] proportional_gain_setting;
    logic [15:0] ti;
    logic [15:0] td;
    logic [7:0]  analog_in_one_function;
    logic [7:0]  analog_in_two_function;
    logic [7:0]  pulse_in_function;
    logic        setpoint_param_select;
    logic [15:0] setpoint_param_value;
    logic [15:0] serial_setpoint_value;
    logic [15:0] serial_source_select;
  } cfg_t;
endpackage

`default_nettype wire

// *** rtl/pid_frequency_controller.sv ***
// PID frequency controller: sources, deviation, P/I/D terms, output modes
// Function
// - Deviation is the setpoint minus the feedback and drives the loop.
// - The P term is the deviation times the proportional gain.
// - The I term integrates the deviation, scaled by the integral time.
// - The D term is the slope of its input times the derivative time.
// - Mode takes 0 to 4, resets to 0, and 0 switches the PID off.
// - In modes 1 and 2 the PID output is the frequency reference.
// - In modes 3 and 4 the PID output is added to the frequency reference.
// - Modes 1 and 3 differentiate the deviation, modes 2 and 4 the feedback.
// - Gain takes 0.00 to 25.00, resets to 1.00 and multiplies the input.
// - In modes 1 and 2 the ordinary frequency reference is the setpoint.
// - In modes 3 and 4 the setpoint comes from analog, pulse or parameter.
// - In modes 3 and 4 the serial setpoint register is used when its select bit is set.
// - Primary feedback comes from analog code B or pulse function 1.
// - Analog code 16 gives a second feedback and enables differential mode.
// - A setpoint, feedback or second feedback assigned to more than one source raises the alarm.
`timescale 1ns/1ps
`include "pid_regs.svh"
`default_nettype none

module pid_frequency_controller #(
  parameter int CTRL_CYC = `CTRL_PERIOD_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Sensor and reference values
  input  wire pid_pkg::sense_t       sense,
  // Register port
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [15:0]           reg_addr,
  input  wire logic [15:0]           reg_wdata,
  output var  logic [15:0]           reg_rdata,
  // Results
  output var  logic signed [15:0]    out_freq,
  output var  logic                  setting_error_alarm,
  output var  logic                  pid_active
);
  import pid_pkg::*;

  typedef struct packed {
    phase_t             ph;
    logic [15:0]        tick;
    cfg_t               cfg;
    logic signed [31:0] integ;
    logic signed [15:0] prev_d;
    logic signed [15:0] dev;
    logic signed [15:0] fb;
    logic signed [15:0] p_t;
    logic signed [15:0] i_t;
    logic signed [15:0] d_t;
    logic signed [15:0] pid;
    logic signed [15:0] out;
    logic [4:0]         status;
    logic [15:0]        rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // Clamp a wide result into the 16-bit signed range
  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF) begin
      sat16 = 16'sh7FFF;
    end else if (v < -48'sh8000) begin
      sat16 = -16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  logic        sp_ain1;
  logic        sp_ain2;
  logic        sp_ps;
  logic        sp_pr;
  logic        sp_sr;
  logic        fb_ain1;
  logic        fb_ain2;
  logic        fb_ps;
  logic        f2_ain1;
  logic        f2_ain2;
  logic [2:0]  sp_cnt;
  logic [1:0]  fb_cnt;
  logic [1:0]  f2_cnt;
  logic        diff_en;
  logic        trim;
  logic        on;
  logic        tick_hit;
  logic signed [15:0] sp;
  logic signed [15:0] fb1;
  logic signed [15:0] fb2;
  logic signed [15:0] efb;

  // Source assignment decode
  assign sp_ain1 = s_reg.cfg.analog_in_one_function == `FN_SP;
  assign sp_ain2 = s_reg.cfg.analog_in_two_function == `FN_SP;
  assign sp_ps   = s_reg.cfg.pulse_in_function == `PULSE_FN_SP;
  assign sp_pr   = s_reg.cfg.setpoint_param_select;
  assign sp_sr   = s_reg.cfg.serial_source_select[`SER_SEL_SP_BIT];
  assign fb_ain1 = s_reg.cfg.analog_in_one_function == `FN_FB;
  assign fb_ain2 = s_reg.cfg.analog_in_two_function == `FN_FB;
  assign fb_ps   = s_reg.cfg.pulse_in_function == `PULSE_FN_FB;
  assign f2_ain1 = s_reg.cfg.analog_in_one_function == `FN_FB2;
  assign f2_ain2 = s_reg.cfg.analog_in_two_function == `FN_FB2;

  // Source counts, used for duplicate detection
  assign sp_cnt = {2'h0, sp_ain1} + {2'h0, sp_ain2} + {2'h0, sp_ps}
                + {2'h0, sp_pr} + {2'h0, sp_sr};
  assign fb_cnt = {1'h0, fb_ain1} + {1'h0, fb_ain2} + {1'h0, fb_ps};
  assign f2_cnt = {1'h0, f2_ain1} + {1'h0, f2_ain2};
  assign diff_en = f2_cnt != 2'h0;

  assign on       = s_reg.cfg.pid_mode_setting != 3'h0;
  assign trim     = s_reg.cfg.pid_mode_setting >= 3'h3;
  assign tick_hit = s_reg.tick == 16'(CTRL_CYC - 1);

  // Setpoint selection; a duplicate only raises the alarm, first match wins
  always_comb begin
    if (!trim) begin
      sp = sense.fref;
    end else if (sp_sr) begin
      sp = $signed(s_reg.cfg.serial_setpoint_value);
    end else if (sp_pr) begin
      sp = $signed(s_reg.cfg.setpoint_param_value);
    end else if (sp_ain1) begin
      sp = sense.a_one;
    end else if (sp_ain2) begin
      sp = sense.a_two;
    end else if (sp_ps) begin
      sp = sense.pulse;
    end else begin
      sp = 16'sh0000;
    end
  end

  // Feedback selection, with the differential subtraction
  always_comb begin
    if (fb_ain1) begin
      fb1 = sense.a_one;
    end else if (fb_ain2) begin
      fb1 = sense.a_two;
    end else if (fb_ps) begin
      fb1 = sense.pulse;
    end else begin
      fb1 = 16'sh0000;
    end
    fb2 = f2_ain1 ? sense.a_one : sense.a_two;
    efb = diff_en ? sat16(48'(fb1) - 48'(fb2)) : fb1;
  end

  // Whole next state: register writes, control period and the PID sequence
  always_comb begin
    logic signed [15:0] d_in;
    logic signed [31:0] acc;
    d_in   = 16'sh0000;
    acc    = 32'sh0;
    s_next = s_reg;
    s_next.tick = tick_hit ? 16'h0000 : s_reg.tick + 16'h0001;
    s_next.status = {on, diff_en, f2_cnt > 2'h1, fb_cnt > 2'h1, sp_cnt > 3'h1};

    // Out-of-range settings are dropped so the stored value stays legal
    if (reg_wr) begin
      unique case (reg_addr)
        `ADR_SER_SP:     s_next.cfg.serial_setpoint_value = reg_wdata;
        `ADR_SER_SEL:    s_next.cfg.serial_source_select = reg_wdata;
        `ADR_MODE: begin
          if (reg_wdata <= 16'(`MODE_MAX)) begin
            s_next.cfg.pid_mode_setting = reg_wdata[2:0];
          end
        end
        `ADR_GAIN: begin
          if (reg_wdata <= `GAIN_MAX) begin
            s_next.cfg.proportional_gain_setting = reg_wdata;
          end
        end
        `ADR_TI:         s_next.cfg.ti = reg_wdata;
        `ADR_TD:         s_next.cfg.td = reg_wdata;
        `ADR_AIN1_FUNC:  s_next.cfg.analog_in_one_function = reg_wdata[7:0];
        `ADR_AIN2_FUNC:  s_next.cfg.analog_in_two_function = reg_wdata[7:0];
        `ADR_PULSE_FUNC: s_next.cfg.pulse_in_function = reg_wdata[7:0];
        `ADR_SP_SEL:     s_next.cfg.setpoint_param_select = reg_wdata[0];
        `ADR_SP_VAL:     s_next.cfg.setpoint_param_value = reg_wdata;
        default: ;
      endcase
    end

    // Read data is registered; unmapped offsets read zero
    if (reg_rd) begin
      unique case (reg_addr)
        `ADR_SER_SP:     s_next.rdata = s_reg.cfg.serial_setpoint_value;
        `ADR_SER_SEL:    s_next.rdata = s_reg.cfg.serial_source_select;
        `ADR_MODE:       s_next.rdata = {13'h0, s_reg.cfg.pid_mode_setting};
        `ADR_GAIN:       s_next.rdata = s_reg.cfg.proportional_gain_setting;
        `ADR_TI:         s_next.rdata = s_reg.cfg.ti;
        `ADR_TD:         s_next.rdata = s_reg.cfg.td;
        `ADR_AIN1_FUNC:  s_next.rdata = {8'h0, s_reg.cfg.analog_in_one_function};
        `ADR_AIN2_FUNC:  s_next.rdata = {8'h0, s_reg.cfg.analog_in_two_function};
        `ADR_PULSE_FUNC: s_next.rdata = {8'h0, s_reg.cfg.pulse_in_function};
        `ADR_SP_SEL:     s_next.rdata = {15'h0, s_reg.cfg.setpoint_param_select};
        `ADR_SP_VAL:     s_next.rdata = s_reg.cfg.setpoint_param_value;
        `ADR_STATUS:     s_next.rdata = {11'h0, s_reg.status};
        `ADR_PID_OUT:    s_next.rdata = s_reg.pid;
        default:         s_next.rdata = 16'h0000;
      endcase
    end

    unique case (s_reg.ph)
      // Sample inputs once per control period
      ST_IDLE: begin
        if (tick_hit) begin
          s_next.dev = sat16(48'(sp) - 48'(efb));
          s_next.fb  = efb;
          s_next.ph  = ST_CALC;
        end
      end
      // Terms from the sampled deviation and feedback
      ST_CALC: begin
        s_next.p_t = sat16((48'(s_reg.dev) * 48'($signed({1'b0,
          s_reg.cfg.proportional_gain_setting}))) / `GAIN_SCALE);
        // Zero integral time turns the I term off and empties it
        if (s_reg.cfg.ti == 16'h0000 || !on) begin
          s_next.integ = 32'sh0;
          s_next.i_t   = 16'sh0000;
        end else begin
          acc = s_reg.integ + 32'(s_reg.dev);
          // Held well inside 32 bits so the sum never wraps
          if (acc > 32'sh3FFFFFFF) begin
            acc = 32'sh3FFFFFFF;
          end else if (acc < -32'sh3FFFFFFF) begin
            acc = -32'sh3FFFFFFF;
          end
          s_next.integ = acc;
          s_next.i_t = sat16(48'(acc) /
            (48'($signed({1'b0, s_reg.cfg.ti})) * `TI_TICKS));
        end
        // Feedback is negated so its slope follows the deviation's while the setpoint holds
        d_in = s_reg.cfg.pid_mode_setting[0] ? s_reg.dev
             : sat16(-48'(s_reg.fb));
        s_next.d_t = sat16((48'(d_in) - 48'(s_reg.prev_d)) *
          48'($signed({1'b0, s_reg.cfg.td})) * `TD_TICKS);
        s_next.prev_d = d_in;
        s_next.ph = ST_APPLY;
      end
      // Sum the terms and steer the output frequency
      ST_APPLY: begin
        s_next.pid = on ? sat16(48'(s_reg.p_t) + 48'(s_reg.i_t)
                              + 48'(s_reg.d_t)) : 16'sh0000;
        if (!on) begin
          s_next.out = sense.fref;
        end else if (!trim) begin
          s_next.out = s_next.pid;
        end else begin
          s_next.out = sat16(48'(sense.fref) + 48'(s_next.pid));
        end
        s_next.ph = ST_IDLE;
      end
      default: s_next.ph = ST_IDLE;
    endcase
  end

  // Single state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.cfg.pid_mode_setting <= `MODE_RST;
      s_reg.cfg.proportional_gain_setting <= `GAIN_RST;
      s_reg.cfg.ti <= `TI_RST;
      s_reg.cfg.td <= `TD_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata           = s_reg.rdata;
  assign out_freq            = s_reg.out;
  assign setting_error_alarm = |s_reg.status[`ST_FB2_ERR:`ST_SP_ERR];
  assign pid_active          = s_reg.status[`ST_ACTIVE];

  // Checks on the sequence and the results
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_MODE_RANGE: assert property (s_reg.cfg.pid_mode_setting <= `MODE_MAX)
    else $error("mode setting out of range");
  AST_GAIN_RANGE: assert property (s_reg.cfg.proportional_gain_setting <= `GAIN_MAX)
    else $error("gain setting out of range");
  AST_SEQUENCE: assert property (s_reg.ph == ST_IDLE && tick_hit
    |=> s_reg.ph == ST_CALC ##1 s_reg.ph == ST_APPLY ##1 s_reg.ph == ST_IDLE)
    else $error("calculation sequence broken");
  AST_DEVIATION: assert property (s_reg.ph == ST_IDLE && tick_hit
    |=> s_reg.dev == sat16(48'($past(sp)) - 48'($past(efb))))
    else $error("deviation not setpoint minus feedback");
  AST_REF_SETPOINT: assert property (s_reg.ph == ST_IDLE && tick_hit && !trim
    && efb == 16'sh0000 |=> s_reg.dev == $past(sense.fref))
    else $error("reference not used as setpoint");
  AST_SERIAL_SP: assert property (s_reg.ph == ST_IDLE && tick_hit && trim && sp_sr
    |=> s_reg.dev == sat16(48'($signed($past(s_reg.cfg.serial_setpoint_value)))
                           - 48'($past(efb))))
    else $error("serial setpoint ignored");
  AST_MODE_OFF: assert property (s_reg.ph == ST_APPLY && !on
    |=> out_freq == $past(sense.fref) && s_reg.pid == 16'sh0000)
    else $error("disabled mode altered the reference");
  AST_DIRECT: assert property (s_reg.ph == ST_APPLY && on && !trim
    |=> out_freq == s_reg.pid)
    else $error("PID output not used as reference");
  AST_TRIM: assert property (s_reg.ph == ST_APPLY && trim
    |=> out_freq == sat16(48'($past(sense.fref)) + 48'(s_reg.pid)))
    else $error("PID output not added to reference");
  AST_I_OFF: assert property (s_reg.ph == ST_CALC && s_reg.cfg.ti == 16'h0000
    |=> s_reg.i_t == 16'sh0000 && s_reg.integ == 32'sh0)
    else $error("integral active with zero time");
  AST_D_OFF: assert property (s_reg.ph == ST_CALC && s_reg.cfg.td == 16'h0000
    |=> s_reg.d_t == 16'sh0000)
    else $error("derivative active with zero time");
  AST_DUP_ALARM: assert property ((sp_cnt > 3'h1 || fb_cnt > 2'h1 || f2_cnt > 2'h1)
    |=> setting_error_alarm)
    else $error("duplicate source without alarm");
  // Alarm is a level, so it must drop once the duplicate is gone
  AST_ALARM_CLEAR: assert property ((sp_cnt <= 3'h1 && fb_cnt <= 2'h1
    && f2_cnt <= 2'h1) |=> !setting_error_alarm)
    else $error("alarm raised without duplicate");
  AST_DIFF_FLAG: assert property ((f2_ain1 || f2_ain2) |=> s_reg.status[`ST_DIFF])
    else $error("second feedback without differential mode");
  AST_OUT_HOLD: assert property (s_reg.ph != ST_APPLY |=> $stable(out_freq))
    else $error("output changed outside the apply step");
  AST_OFF_CLEARS_I: assert property (s_reg.ph == ST_CALC && !on
    |=> s_reg.integ == 32'sh0)
    else $error("integrator kept while disabled");

  COV_DIRECT: cover property (s_reg.ph == ST_APPLY && s_reg.cfg.pid_mode_setting == 3'h1);
  COV_TRIM_FB: cover property (s_reg.ph == ST_APPLY && s_reg.cfg.pid_mode_setting == 3'h4);
  COV_DIFF: cover property (s_reg.ph == ST_CALC && diff_en && on);
  COV_ALARM: cover property (setting_error_alarm);
  COV_SERIAL: cover property (s_reg.ph == ST_IDLE && tick_hit && trim && sp_sr);

endmodule // pid_frequency_controller

`default_nettype wire

// *** verif/pid_sensor_model.sv ***
// Sensor and reference source model feeding the controller's sense inputs
`timescale 1ns/1ps
`default_nettype none

module pid_sensor_model (
  // Clock
  input  wire logic            core_clk,
  // Values presented to the controller
  output var  pid_pkg::sense_t sense
);
  import pid_pkg::*;

  // Levels start at zero so no unknown reaches the loop
  initial begin
    sense = '0;
  end

  // Steady levels; caller changes them just after a clock edge only
  task automatic set_levels(input logic signed [15:0] in_one, in_two, pl, fr);
    sense = '{a_one: in_one, a_two: in_two, pulse: pl, fref: fr};
  endtask
endmodule // pid_sensor_model

`default_nettype wire

// *** verif/pid_frequency_controller_tb_top.sv ***
// Self-checking testbench of the PID frequency controller
`timescale 1ns/1ps
`include "pid_regs.svh"
`default_nettype none
`define CHK(what, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("[ERR] %s expected %h seen %h", what, exp, got); \
  end \
end

module pid_frequency_controller_tb_top;
  import pid_pkg::*;
  // Short control period keeps the run brief
  localparam int CTRL = 8;

  logic               core_clk  = 1'b0;
  logic               rst       = 1'b1;
  logic               reg_wr    = 1'b0;
  logic               reg_rd    = 1'b0;
  logic [15:0]        reg_addr  = 16'h0000;
  logic [15:0]        reg_wdata = 16'h0000;
  logic [15:0]        reg_rdata;
  logic signed [15:0] out_freq;
  logic               setting_error_alarm;
  logic               pid_active;
  sense_t             sense;
  int                 fails     = 0;
  int                 tests_run = 0;

  pid_frequency_controller #(.CTRL_CYC(CTRL)) i_dut (
    .core_clk(core_clk), .rst(rst), .sense(sense), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .out_freq(out_freq), .setting_error_alarm(setting_error_alarm), .pid_active(pid_active));
  pid_sensor_model i_sensors (.core_clk(core_clk), .sense(sense));

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  // Register access; every task starts and ends 1 ns after an edge
  task automatic wr(input logic [15:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    // Idle edge so a following write never re-raises the strobe at once
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
  endtask
  // Whole control periods; out_freq stands for a full period
  task automatic settle(input int periods);
    repeat (periods * CTRL) @(posedge core_clk);
    #1;
  endtask
  task automatic cfg(input logic [15:0] m, g, ti, td, f1, f2, fp, ss);
    wr(`ADR_MODE, m);
    wr(`ADR_GAIN, g);
    wr(`ADR_TI, ti);
    wr(`ADR_TD, td);
    wr(`ADR_AIN1_FUNC, f1);
    wr(`ADR_AIN2_FUNC, f2);
    wr(`ADR_PULSE_FUNC, fp);
    wr(`ADR_SP_SEL, ss);
    wr(`ADR_SER_SEL, 16'h0000);
  endtask
  // Extremes of out_freq over three periods, for one-period spikes
  task automatic watch(output logic signed [15:0] lo, hi);
    lo = out_freq;
    hi = out_freq;
    repeat (3 * CTRL) begin
      @(posedge core_clk);
      #1;
      if (out_freq > hi) hi = out_freq;
      if (out_freq < lo) lo = out_freq;
    end
  endtask

  task automatic t_reset();
    logic [15:0] v;
    `CHK("out_freq", 16'h0000, out_freq)
    `CHK("pid_active", 1'b0, pid_active)
    rd(`ADR_MODE, v);
    `CHK("mode", 16'h0000, v)
    rd(`ADR_GAIN, v);
    `CHK("gain", 16'h0064, v)
    rd(16'h0200, v);
    `CHK("unmapped", 16'h0000, v)
  endtask

  // Out-of-range settings must leave the old value
  task automatic t_limits();
    logic [15:0] v;
    wr(`ADR_MODE, 16'h0005);
    rd(`ADR_MODE, v);
    `CHK("mode 5", 16'h0000, v)
    wr(`ADR_MODE, 16'h0004);
    rd(`ADR_MODE, v);
    `CHK("mode 4", 16'h0004, v)
    `CHK("active", 1'b1, pid_active)
    wr(`ADR_GAIN, 16'h09C5);
    rd(`ADR_GAIN, v);
    `CHK("gain over", 16'h0064, v)
    wr(`ADR_GAIN, 16'h09C4);
    rd(`ADR_GAIN, v);
    `CHK("gain max", 16'h09C4, v)
  endtask

  task automatic t_mode_off();
    cfg(16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h000B, 16'h0000, 16'h0000, 16'h0000);
    i_sensors.set_levels(16'sh0064, 16'sh0000, 16'sh0000, 16'sh012C);
    settle(3);
    `CHK("off out", 16'h012C, out_freq)
    `CHK("off active", 1'b0, pid_active)
  endtask

  // Modes 1 and 2: PID output alone, setpoint is the reference
  task automatic t_direct();
    for (int m = 1; m <= 2; m++) begin
      cfg(16'(m), 16'h0064, 16'h0000, 16'h0000, 16'h000B, 16'h0000, 16'h0000, 16'h0000);
      i_sensors.set_levels(16'sh0064, 16'sh0000, 16'sh0000, 16'sh0190);
      settle(3);
      `CHK("direct", 16'h012C, out_freq)
      wr(`ADR_GAIN, 16'h00C8);
      settle(3);
      `CHK("gain 2", 16'h0258, out_freq)
    end
  endtask

  // Modes 3 and 4: trim, with setpoint from analog, parameter, serial
  task automatic t_trim();
    for (int m = 3; m <= 4; m++) begin
      cfg(16'(m), 16'h0064, 16'h0000, 16'h0000, 16'h000B, 16'h000C, 16'h0000, 16'h0000);
      i_sensors.set_levels(16'sh00C8, 16'sh01F4, 16'sh0000, 16'sh03E8);
      settle(3);
      `CHK("trim", 16'h0514, out_freq)
      `CHK("no dup", 1'b0, setting_error_alarm)
      wr(`ADR_SP_VAL, 16'h0032);
      wr(`ADR_SP_SEL, 16'h0001);
      settle(3);
      `CHK("param sp", 16'h0352, out_freq)
      `CHK("sp dup", 1'b1, setting_error_alarm)
      wr(`ADR_SER_SP, 16'h02BC);
      wr(`ADR_SER_SEL, 16'h0001 << `SER_SEL_SP_BIT);
      settle(3);
      `CHK("serial sp", 16'h05DC, out_freq)
    end
  endtask

  task automatic t_diff();
    logic [15:0] v;
    cfg(16'h0003, 16'h0064, 16'h0000, 16'h0000, 16'h000B, 16'h0016, 16'h0002, 16'h0000);
    i_sensors.set_levels(16'sh0190, 16'sh0064, 16'sh0258, 16'sh0000);
    settle(3);
    `CHK("diff out", 16'h012C, out_freq)
    rd(`ADR_STATUS, v);
    `CHK("status", 16'h0018, v)
    wr(`ADR_PULSE_FUNC, 16'h0001);
    settle(1);
    `CHK("fb dup", 1'b1, setting_error_alarm)
  endtask

  // With gain 0 and ti 0.1 s the I term climbs one unit a period
  task automatic t_integral();
    logic [15:0] v;
    cfg(16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h000B, 16'h0000, 16'h0000, 16'h0000);
    i_sensors.set_levels(16'sh0000, 16'sh0000, 16'sh0000, 16'sh0064);
    settle(2);
    wr(`ADR_MODE, 16'h0001);
    settle(3);
    v = out_freq;
    settle(1);
    `CHK("i step", 16'h0001, 16'(out_freq - v))
    wr(`ADR_TI, 16'h0000);
    settle(2);
    `CHK("i off", 16'h0000, out_freq)
  endtask

  // D term: spike of one period on the differentiated signal only
  task automatic t_deriv();
    logic signed [15:0] lo, hi;
    cfg(16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h000B, 16'h0000, 16'h0000, 16'h0000);
    i_sensors.set_levels(16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000);
    settle(3);
    i_sensors.set_levels(16'sh0000, 16'sh0000, 16'sh0000, 16'sh0032);
    watch(lo, hi);
    `CHK("d dev", 16'h01F4, hi)
    `CHK("d gone", 16'h0000, out_freq)
    wr(`ADR_MODE, 16'h0002);
    i_sensors.set_levels(16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000);
    settle(3);
    i_sensors.set_levels(16'sh0000, 16'sh0000, 16'sh0000, 16'sh0032);
    watch(lo, hi);
    `CHK("d sp", 16'h0000, hi)
    i_sensors.set_levels(16'sh0032, 16'sh0000, 16'sh0000, 16'sh0032);
    watch(lo, hi);
    `CHK("d fb", 16'hFE0C, lo)
  endtask

  task automatic tally_and_finish();
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence after three cycles of reset
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_limits();
    t_mode_off();
    t_direct();
    t_trim();
    t_diff();
    t_integral();
    t_deriv();
    tally_and_finish();
  end

  // Cuts a hang short; the run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    tally_and_finish();
  end
endmodule // pid_frequency_controller_tb_top

`default_nettype wire
